// >>> hw/bru_pkg.sv
/*
 * bru_pkg: constants, types and helpers shared by the block RAM unit.
 * Assumes a 32-bit APB register slave and fabric ports on one clock.
 */
package bru_pkg;

    // ****************************************
    // array geometry
    // ****************************************
    localparam int BRU_BITS      = 18432;
    localparam int BRU_CORE_BITS = 16384;
    localparam int BRU_AW        = 14;
    localparam int BRU_DW        = 36;

    // ****************************************
    // register map (byte offsets) and reset values
    // ****************************************
    localparam logic [11:0] BRU_CTRL_OFF   = 12'h000;
    localparam logic [11:0] BRU_STATUS_OFF = 12'h004;
    localparam logic [11:0] BRU_INFO_OFF   = 12'h008;
    localparam logic [8:0]  BRU_CTRL_RST   = 9'h000;

    // ctrl field positions
    localparam int BRU_MODE_LSB = 0;
    localparam int BRU_OREG_A   = 2;
    localparam int BRU_OREG_B   = 3;
    localparam int BRU_WMA_LSB  = 4;
    localparam int BRU_WMB_LSB  = 6;
    localparam int BRU_LOCK     = 8;
    // status field positions
    localparam int BRU_ST_TDPW  = 0;
    localparam int BRU_ST_RBWA  = 1;
    localparam int BRU_ST_RBWB  = 2;
    localparam int BRU_ST_LOCK  = 3;
    // info field positions
    localparam int BRU_INFO_B   = 8;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        BRU_SINGLE, BRU_TRUE_DP, BRU_PSEUDO_DP
    } bru_mode_e;
    typedef enum logic [1:0] {
        BRU_NORMAL, BRU_WTHRU, BRU_RBW
    } bru_wmode_e;
    typedef struct packed {
        logic              en;
        logic              cs;
        logic              we;
        logic [BRU_AW-1:0] addr;
        logic [BRU_DW-1:0] wdata;
    } bru_req_s;
    typedef struct packed {
        logic              valid;
        logic [BRU_DW-1:0] data;
    } bru_rsp_s;

    // ninth-bit shapes use the whole array, the others the core only
    function automatic int bru_depth(input int w);
        return ((w % 9) == 0 ? BRU_BITS : BRU_CORE_BITS) / w;
    endfunction : bru_depth

    function automatic logic bru_rbw_ok(input int w);
        return (w == 9) || (w == 18) || (w == 36);
    endfunction : bru_rbw_ok

endpackage : bru_pkg

// >>> hw/bru_mem.sv
/*
 * bru_mem: the bit array of the block RAM unit with two word ports
 * and a registered read word per port.
 * Assumes requests arrive already registered and range-checked.
 */
`timescale 1ns/1ps
module bru_mem #(
    parameter int                            WA   = 9,
    parameter int                            WB   = 9,
    parameter logic [bru_pkg::BRU_BITS-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // port a
    input  wire logic                       a_en,
    input  wire logic                       a_we,
    input  wire logic [bru_pkg::BRU_AW-1:0] a_addr,
    input  wire logic [WA-1:0]              a_wd,
    input  wire bru_pkg::bru_wmode_e        a_wm,
    output logic      [WA-1:0]              a_q,
    // port b
    input  wire logic                       b_en,
    input  wire logic                       b_we,
    input  wire logic [bru_pkg::BRU_AW-1:0] b_addr,
    input  wire logic [WB-1:0]              b_wd,
    input  wire bru_pkg::bru_wmode_e        b_wm,
    output logic      [WB-1:0]              b_q
);
    import bru_pkg::*;

    logic [BRU_BITS-1:0] mem_r;
    int                  a_base;
    int                  b_base;

    // word n sits at bits n*w upward, lsb first, on either port  // R3
    assign a_base = int'(a_addr) * WA;
    assign b_base = int'(b_addr) * WB;

    // array: reset stands in for the configuration preload  // R4
    // b is written first so a wins a same-bit collision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_r <= INIT;
        end else begin
            if (b_en && b_we) begin
                mem_r[b_base +: WB] <= b_wd;
            end
            if (a_en && a_we) begin
                mem_r[a_base +: WA] <= a_wd;
            end
        end
    end

    // port a read word; old contents are read before the write lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= '0;
        end else if (a_en) begin
            if (!a_we) begin
                a_q <= mem_r[a_base +: WA];
            end else if (a_wm == BRU_WTHRU) begin
                a_q <= a_wd; // R8
            end else if (a_wm == BRU_RBW) begin
                a_q <= mem_r[a_base +: WA]; // R9
            end
        end
    end

    // port b read word, same write behaviours as port a
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_q <= '0;
        end else if (b_en) begin
            if (!b_we) begin
                b_q <= mem_r[b_base +: WB];
            end else if (b_wm == BRU_WTHRU) begin
                b_q <= b_wd; // R8
            end else if (b_wm == BRU_RBW) begin
                b_q <= mem_r[b_base +: WB]; // R9
            end
        end
    end

endmodule : bru_mem

// >>> hw/bru_top.sv
/*
 * bru_top: block RAM unit with two fabric ports and an APB slave
 * for configuration and status.
 * Assumes fabric requests are synchronous to pclk and APB is 32 bits.
 */
// Overview of operation
// R1: shapes 16384x1 to 512x36; no 36-bit port in true dual-port mode.
// R2: each port of a multi-port mode has its own independent width.
// R3: word zero fills the lowest bits, lsb first, on every port.
// R4: contents preload at configuration; writes held off make a ROM.
// R5: address and write data are registered before the array.
// R6: each port has an optional, bypassable output register.
// R7: normal mode: output updates on reads only, never on writes.
// R8: write-through mode: the written data appear on that port's output.
// R9: read-before-write shows old contents; only at 9, 18, 36 bits.
// R10: blocks combine wider or deeper via external decode and steering.
// R11: read data valid one clock after capture, two with output register.
`timescale 1ns/1ps
module bru_top #(
    parameter int                            WIDTH_A = 9,
    parameter int                            WIDTH_B = 9,
    parameter logic [bru_pkg::BRU_BITS-1:0] INIT    = '0
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // fabric port a
    input  wire bru_pkg::bru_req_s req_a,
    output bru_pkg::bru_rsp_s      rsp_a,
    // fabric port b
    input  wire bru_pkg::bru_req_s req_b,
    output bru_pkg::bru_rsp_s      rsp_b
);
    import bru_pkg::*;

    localparam int DEPTH_A = bru_depth(WIDTH_A); // R1
    localparam int DEPTH_B = bru_depth(WIDTH_B); // R1

    // ****************************************
    // configuration
    // ****************************************
    logic [8:0]  ctrl_r;
    logic        lockhit_r;
    logic [31:0] prdata_r;
    bru_mode_e   mode;
    bru_wmode_e  wm_req_a;
    bru_wmode_e  wm_req_b;
    bru_wmode_e  wm_a;
    bru_wmode_e  wm_b;
    logic        oreg_a;
    logic        oreg_b;
    logic        lock;
    logic        cfg_err;
    logic        rbw_bad_a;
    logic        rbw_bad_b;

    // the undefined mode code falls back to single port
    always_comb begin
        case (ctrl_r[BRU_MODE_LSB +: 2])
            2'h1:    mode = BRU_TRUE_DP;
            2'h2:    mode = BRU_PSEUDO_DP;
            default: mode = BRU_SINGLE;
        endcase
    end

    assign wm_req_a = bru_wmode_e'(ctrl_r[BRU_WMA_LSB +: 2]);
    assign wm_req_b = bru_wmode_e'(ctrl_r[BRU_WMB_LSB +: 2]);
    assign oreg_a   = ctrl_r[BRU_OREG_A];
    assign oreg_b   = ctrl_r[BRU_OREG_B];
    assign lock     = ctrl_r[BRU_LOCK];

    // a 36-bit port cannot run true dual port; both ports halt  // R1
    assign cfg_err = (mode == BRU_TRUE_DP) && (WIDTH_A == 36 || WIDTH_B == 36);

    // read-before-write at other widths degrades to normal  // R9
    assign rbw_bad_a = (wm_req_a == BRU_RBW) && !bru_rbw_ok(WIDTH_A);
    assign rbw_bad_b = (wm_req_b == BRU_RBW) && !bru_rbw_ok(WIDTH_B);
    // write-through passes unchanged; the spare code 3 acts as normal  // R8
    assign wm_a = (rbw_bad_a || ctrl_r[BRU_WMA_LSB +: 2] == 2'h3)
                ? BRU_NORMAL : wm_req_a;
    assign wm_b = (rbw_bad_b || ctrl_r[BRU_WMB_LSB +: 2] == 2'h3)
                ? BRU_NORMAL : wm_req_b;

    // ****************************************
    // apb slave
    // ****************************************
    logic acc;
    logic hit;

    assign acc    = psel && penable;
    assign hit    = (paddr == BRU_CTRL_OFF) || (paddr == BRU_STATUS_OFF)
                 || (paddr == BRU_INFO_OFF);
    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = acc && !hit;
    assign prdata  = prdata_r;

    // control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= BRU_CTRL_RST;
        end else if (acc && pwrite && paddr == BRU_CTRL_OFF) begin
            ctrl_r <= pwdata[8:0];
        end
    end

    // read data is fetched in the setup cycle, so no wait is needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == BRU_CTRL_OFF) begin
                prdata_r <= {23'h0, ctrl_r};
            end else if (paddr == BRU_STATUS_OFF) begin
                prdata_r <= {28'h0, lockhit_r, rbw_bad_b, rbw_bad_a, cfg_err};
            end else if (paddr == BRU_INFO_OFF) begin
                prdata_r <= (32'(WIDTH_B) << BRU_INFO_B) | 32'(WIDTH_A);
            end else begin
                prdata_r <= '0;
            end
        end
    end

    // ****************************************
    // request capture
    // ****************************************
    bru_req_s in_a_r;
    bru_req_s in_b_r;
    logic     a_take;
    logic     b_take;
    logic     a_out_ok;
    logic     b_rd_ok;

    // pseudo dual port: a writes only, b reads only  // R2
    assign a_out_ok = (mode != BRU_PSEUDO_DP);
    assign b_rd_ok  = (mode != BRU_SINGLE);

    // chip select lets outside decode pick one of several units  // R10
    assign a_take = req_a.en && req_a.cs && !cfg_err
                 && (int'(req_a.addr) < DEPTH_A) && (req_a.we || a_out_ok);
    assign b_take = req_b.en && req_b.cs && !cfg_err && b_rd_ok
                 && (int'(req_b.addr) < DEPTH_B)
                 && (!req_b.we || mode == BRU_TRUE_DP);

    // address and write data registered at the array input  // R5
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_a_r <= '0;
            in_b_r <= '0;
        end else begin
            in_a_r    <= req_a;
            in_a_r.en <= a_take;
            in_b_r    <= req_b;
            in_b_r.en <= b_take;
        end
    end

    // ****************************************
    // array and write behaviour
    // ****************************************
    logic               mem_en_a;
    logic               mem_en_b;
    logic               mem_we_a;
    logic               mem_we_b;
    logic [WIDTH_A-1:0] q_a;
    logic [WIDTH_B-1:0] q_b;

    // a locked unit drops writes outright, keeping it read-only  // R4
    assign mem_en_a = in_a_r.en && !(in_a_r.we && lock);
    assign mem_en_b = in_b_r.en && !(in_b_r.we && lock);
    assign mem_we_a = mem_en_a && in_a_r.we;
    assign mem_we_b = mem_en_b && in_b_r.we;

    bru_mem #(
        .WA   (WIDTH_A),
        .WB   (WIDTH_B),
        .INIT (INIT)
    ) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .a_en    (mem_en_a),
        .a_we    (mem_we_a),
        .a_addr  (in_a_r.addr),
        .a_wd    (in_a_r.wdata[WIDTH_A-1:0]),
        .a_wm    (wm_a),
        .a_q     (q_a),
        .b_en    (mem_en_b),
        .b_we    (mem_we_b),
        .b_addr  (in_b_r.addr),
        .b_wd    (in_b_r.wdata[WIDTH_B-1:0]),
        .b_wm    (wm_b),
        .b_q     (q_b)
    );

    // refused writes leave a sticky mark; a new hit beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lockhit_r <= 1'b0;
        end else if (lock && (in_a_r.en && in_a_r.we
                           || in_b_r.en && in_b_r.we)) begin
            lockhit_r <= 1'b1; // R4
        end else if (acc && pwrite && paddr == BRU_STATUS_OFF
                     && pwdata[BRU_ST_LOCK]) begin
            lockhit_r <= 1'b0;
        end
    end

    // ****************************************
    // output stage
    // ****************************************
    logic              qv_a_r;
    logic              qv_b_r;
    logic              ov_a_r;
    logic              ov_b_r;
    logic [BRU_DW-1:0] qx_a;
    logic [BRU_DW-1:0] qx_b;
    logic [BRU_DW-1:0] out_a_r;
    logic [BRU_DW-1:0] out_b_r;

    // narrow words sit in the low bits, upper bits read zero
    always_comb begin
        qx_a              = '0;
        qx_a[WIDTH_A-1:0] = q_a;
        qx_b              = '0;
        qx_b[WIDTH_B-1:0] = q_b;
    end

    // a write in normal mode yields no output at all  // R7
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qv_a_r <= 1'b0;
            qv_b_r <= 1'b0;
        end else begin
            qv_a_r <= mem_en_a && a_out_ok
                   && (!in_a_r.we || wm_a != BRU_NORMAL); // R11
            qv_b_r <= mem_en_b && (!in_b_r.we || wm_b != BRU_NORMAL); // R11
        end
    end

    // optional output register, one more clock of latency  // R6
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_a_r <= '0;
            out_b_r <= '0;
            ov_a_r  <= 1'b0;
            ov_b_r  <= 1'b0;
        end else begin
            out_a_r <= qx_a;
            out_b_r <= qx_b;
            ov_a_r  <= qv_a_r;
            ov_b_r  <= qv_b_r;
        end
    end

    // bypass mux; both legs come straight from flops  // R6
    assign rsp_a = oreg_a ? {ov_a_r, out_a_r} : {qv_a_r, qx_a};
    assign rsp_b = oreg_b ? {ov_b_r, out_b_r} : {qv_b_r, qx_b};

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_read_direct: assert property ( // R11
        a_take && !req_a.we && !oreg_a ##1 !oreg_a[*2] |-> rsp_a.valid)
        else $error("port a read not valid one clock after capture");

    a_read_oreg: assert property ( // R11
        a_take && !req_a.we && oreg_a ##1 oreg_a[*3] |-> rsp_a.valid)
        else $error("port a read not valid two clocks after capture");

    a_capture_addr: assert property ( // R5
        a_take |=> in_a_r.en && in_a_r.addr == $past(req_a.addr))
        else $error("port a address not captured");

    a_cs_gate: assert property ( // R10
        !req_b.cs |-> ##2 !qv_b_r)
        else $error("unselected port b produced data");

    a_wthru_echo: assert property ( // R8
        a_take && req_a.we && wm_req_a == BRU_WTHRU && !lock && a_out_ok
        && !oreg_a ##1 (wm_req_a == BRU_WTHRU && !oreg_a)[*2]
        |-> rsp_a.valid && rsp_a.data[WIDTH_A-1:0]
            == $past(req_a.wdata[WIDTH_A-1:0], 2))
        else $error("write-through data not echoed");

    a_normal_quiet: assert property ( // R7
        b_take && req_b.we && wm_b == BRU_NORMAL && !lock && !oreg_b
        ##1 !oreg_b[*2] |-> !rsp_b.valid)
        else $error("normal-mode write produced output");

    a_rbw_width: assert property ( // R9
        wm_a == BRU_RBW |-> bru_rbw_ok(WIDTH_A) && !rbw_bad_a)
        else $error("read-before-write at an unsupported width");

    a_lock_mark: assert property ( // R4
        lock && a_take && req_a.we ##1 lock |-> ##1 lockhit_r && !$past(mem_we_a))
        else $error("locked write not refused");

    a_tdp_wide: assert property ( // R1
        cfg_err |=> !in_a_r.en && !in_b_r.en)
        else $error("36-bit true dual port request accepted");

    a_b_read_direct: assert property ( // R2
        b_take && !req_b.we && !oreg_b ##1 !oreg_b[*2] |-> rsp_b.valid)
        else $error("port b read not valid one clock after capture");

    c_read_a: cover property (a_take && !req_a.we ##2 rsp_a.valid);
    c_wthru:  cover property (mem_we_a && wm_a == BRU_WTHRU);
    c_oreg_b: cover property (oreg_b && ov_b_r);
    c_lock:   cover property ($rose(lockhit_r));

endmodule : bru_top

// >>> test/bru_fabric_model.sv
/*
 * bru_fabric_model: fabric user logic that drives both request ports
 * of the block RAM unit and collects the answers.
 * Assumes pclk runs freely and the bench calls access() just after
 * a rising edge, one transfer at a time.
 */
`timescale 1ns/1ps
module bru_fabric_model (
    // clock
    input  wire logic              pclk,
    // requests towards the block
    output bru_pkg::bru_req_s      req_a,
    output bru_pkg::bru_req_s      req_b,
    // answers from the block
    input  wire bru_pkg::bru_rsp_s rsp_a,
    input  wire bru_pkg::bru_rsp_s rsp_b
);
    import bru_pkg::*;

    // ****************************************
    // idle state
    // ****************************************
    initial begin
        req_a = '0;
        req_b = '0;
    end

    // ****************************************
    // one transfer: drive, release, wait for the answer
    // ****************************************
    // lat counts edges after the capture edge; 0 means no answer came
    task automatic access(input  logic        pb,
                          input  logic        we,
                          input  logic [13:0] ad,
                          input  logic [35:0] wd,
                          output logic [35:0] rd,
                          output int          lat);
        lat = 0;
        rd  = '0;
        @(posedge pclk);
        // cs stands for the outside decode choosing this block
        if (pb) begin
            req_b <= {2'b11, we, ad, wd};
        end else begin
            req_a <= {2'b11, we, ad, wd};
        end
        @(posedge pclk);
        // released lines show the inverse so stale values never match
        if (pb) begin
            req_b <= {3'b000, ~ad, ~wd};
        end else begin
            req_a <= {3'b000, ~ad, ~wd};
        end
        for (int k = 1; k <= 6; k++) begin
            @(posedge pclk);
            if (lat == 0 && (pb ? rsp_b.valid : rsp_a.valid) === 1'b1) begin
                lat = k;
                rd  = pb ? rsp_b.data : rsp_a.data;
            end
        end
    endtask : access

endmodule : bru_fabric_model

// >>> test/embedded_block_ram_tb.sv
/*
 * embedded_block_ram_tb: self-checking bench for the block RAM unit,
 * port a 9 bits wide, port b 18 bits wide, small known preload.
 * Assumes zero-wait APB and the fabric model for both ports.
 */
`timescale 1ns/1ps
module embedded_block_ram_tb;
    import bru_pkg::*;

    // ****************************************
    // signals
    // ****************************************
    localparam logic [BRU_BITS-1:0] PRE =
        {{(BRU_BITS-36){1'b0}}, 36'h9_D1F5_A3C7};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    bru_req_s    req_a;
    bru_req_s    req_b;
    bru_rsp_s    rsp_a;
    bru_rsp_s    rsp_b;
    int          failures  = 0;
    int          tests_run = 0;
    logic [35:0] rd;
    logic [31:0] rv;
    logic        err;
    int          lat;

    bru_top #(.WIDTH_A(9), .WIDTH_B(18), .INIT(PRE)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_a(req_a), .rsp_a(rsp_a),
        .req_b(req_b), .rsp_b(rsp_b));

    bru_fabric_model fab (
        .pclk(pclk), .req_a(req_a), .req_b(req_b),
        .rsp_a(rsp_a), .rsp_b(rsp_b));

    // ****************************************
    // clock and watchdog
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        stop_test();
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string nm, input logic [35:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one APB transfer; holds everything until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // registers after reset, widths and an unmapped place
        apb(1'b0, BRU_CTRL_OFF, 32'h0);
        check("ctrl reset", rv, 36'h0);
        apb(1'b0, BRU_INFO_OFF, 32'h0);
        check("info widths", rv, 36'h0_0000_1209);
        apb(1'b0, 12'h00C, 32'h0);
        check("unmapped error", err, 36'h1);
        // preloaded words, word zero in the lowest bits
        fab.access(1'b0, 1'b0, 14'h0, 36'h0, rd, lat);
        check("a word0", rd, PRE[8:0]);
        check("a latency plain", lat, 36'h2);
        fab.access(1'b0, 1'b0, 14'h1, 36'h0, rd, lat);
        check("a word1", rd, PRE[17:9]);
        // true dual: port b sees the same bits as one 18-bit word
        apb(1'b1, BRU_CTRL_OFF, 32'h1);
        fab.access(1'b1, 1'b0, 14'h0, 36'h0, rd, lat);
        check("b word0", rd, PRE[17:0]);
        // last word of each shape answers, one past it does not
        fab.access(1'b1, 1'b0, 14'h3FF, 36'h0, rd, lat);
        check("b last word", lat, 36'h2);
        fab.access(1'b1, 1'b0, 14'h400, 36'h0, rd, lat);
        check("b past depth", lat, 36'h0);
        fab.access(1'b0, 1'b0, 14'h7FF, 36'h0, rd, lat);
        check("a last word", lat, 36'h2);
        fab.access(1'b0, 1'b0, 14'h800, 36'h0, rd, lat);
        check("a past depth", lat, 36'h0);
        // normal write: no answer, output keeps the last read word
        fab.access(1'b0, 1'b1, 14'h5, 36'h155, rd, lat);
        check("normal write answer", lat, 36'h0);
        check("normal write output", rsp_a.data, 36'h0);
        fab.access(1'b0, 1'b0, 14'h5, 36'h0, rd, lat);
        check("normal write stored", rd, 36'h155);
        // write-through with the output register off
        apb(1'b1, BRU_CTRL_OFF, 32'h11);
        fab.access(1'b0, 1'b1, 14'h7, 36'h0F0, rd, lat);
        check("through direct data", rd, 36'h0F0);
        check("through direct latency", lat, 36'h2);
        // write-through with the output register on
        apb(1'b1, BRU_CTRL_OFF, 32'h15);
        fab.access(1'b0, 1'b1, 14'h6, 36'h0AA, rd, lat);
        check("through data", rd, 36'h0AA);
        check("through latency", lat, 36'h3);
        // read-before-write shows the old word, stores the new one
        apb(1'b1, BRU_CTRL_OFF, 32'h21);
        fab.access(1'b0, 1'b1, 14'h6, 36'h133, rd, lat);
        check("rbw old data", rd, 36'h0AA);
        fab.access(1'b0, 1'b0, 14'h6, 36'h0, rd, lat);
        check("rbw stored", rd, 36'h133);
        // narrow writes on a read back through the wide port
        apb(1'b1, BRU_CTRL_OFF, 32'h1);
        fab.access(1'b0, 1'b1, 14'h2, 36'h1C3, rd, lat);
        fab.access(1'b0, 1'b1, 14'h3, 36'h04E, rd, lat);
        fab.access(1'b1, 1'b0, 14'h1, 36'h0, rd, lat);
        check("mixed width word", rd, 36'h0_0000_9DC3);
        // normal write on the wide port: no answer, word still stored
        fab.access(1'b1, 1'b1, 14'h8, 36'h2_5A5A, rd, lat);
        check("b normal write answer", lat, 36'h0);
        fab.access(1'b1, 1'b0, 14'h8, 36'h0, rd, lat);
        check("b write stored", rd, 36'h2_5A5A);
        // locked: writes dropped, refusal flagged, cleared by one
        apb(1'b1, BRU_CTRL_OFF, 32'h101);
        fab.access(1'b0, 1'b1, 14'h0, 36'h0FF, rd, lat);
        apb(1'b0, BRU_STATUS_OFF, 32'h0);
        check("lock flag", rv[BRU_ST_LOCK], 36'h1);
        fab.access(1'b0, 1'b0, 14'h0, 36'h0, rd, lat);
        check("rom contents", rd, PRE[8:0]);
        apb(1'b1, BRU_STATUS_OFF, 32'h8);
        apb(1'b0, BRU_STATUS_OFF, 32'h0);
        check("lock flag clear", rv[BRU_ST_LOCK], 36'h0);
        stop_test();
    end

endmodule : embedded_block_ram_tb
